/* File: hw/ast_uart.sv */
// Asynchronous serial transceiver with a classic Wishbone register slave.
//
// Function
// (RULE1) Falling edge rechecked half bit later.
// (RULE2) Valid start then sample each bit centre.
// (RULE3) Least significant bit travels first.
// (RULE4) Char to holding register, ready set, zero-fill.
// (RULE5) Rehunt after stop; low framing tail restarts.
// (RULE6) Error flags load at character end.
// (RULE7) Break gives one zero char, break flag.
// (RULE8) After break wait one high bit.
// (RULE9) Idle transmitter holds high, sets underrun.
// (RULE10) Break command drives line low.
// (RULE11) Disabled transmitter finishes current character.
// (RULE12) Length field gives five to eight bits.
// (RULE13) Transmit one or two stops, check one.
// (RULE14) Parity added and checked, sense selectable.
// (RULE15) Low six mode bits change live.
// (RULE16) Change operating mode only while disabled.
// (RULE17) Mode 00 normal, 01 automatic echo.
// (RULE18) Echo loads received chars into transmitter.
// (RULE19) Echo needs receiver, transmitter enable optional.
// (RULE20) Echo cuts CPU transmit path, ready clear.
// (RULE21) Echo keeps the received parity bit.
// (RULE22) Echo sends only first break character.
// (RULE23) Overrun and errors clear by command bit.
// (RULE24) Reading receive holding clears ready.
// (RULE25) Length codes 00..11 mean 5..8 bits.
// (RULE26) Parity codes none, forced, normal; set=even.
// (RULE27) Sixteen times clock, check at eight.
`timescale 1ns/1ps
`include "ast_regs.svh"

module ast_uart (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire ast_pkg::ast_word_t WB_DAT_IN,
   output ast_pkg::ast_word_t WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic RXD_IN,
   output logic TXD_OUT
);
   import ast_pkg::*;

   ast_state_t s_q;
   ast_state_t s_d;
   logic tick;
   logic rsample;
   logic tend;
   logic req;
   logic echo;
   logic par_en;
   logic [2:0] last_bit;
   logic rx_load;
   logic rx_brk_ev;
   logic stop_done;
   logic thr_new;

   always_comb begin
      s_d = s_q;
      thr_new = 1'b0;
      rx_load = 1'b0;
      rx_brk_ev = 1'b0;
      stop_done = 1'b0;
      // Two stage synchroniser; edge logic compares the second stage with a third, delayed copy.
      s_d.rx_m = RXD_IN;
      s_d.rx_s = s_q.rx_m;
      s_d.rx_p = s_q.rx_s;
      // Sixteen times bit clock shared by both directions.
      tick = (s_q.div == 16'h0000);
      s_d.div = tick ? s_q.bit_rate_control_reg : s_q.div - 16'h0001;
      echo = (s_q.mode[`AST_MODE_OP_LO +: 2] == 2'b01); // see (RULE17)
      par_en = (s_q.mode[`AST_MODE_PAR_LO +: 2] != 2'b00); // see (RULE26)
      last_bit = 3'd4 + {1'b0, s_q.mode[`AST_MODE_LEN_LO +: 2]}; // see (RULE25)

      // Register slave: one wait state, ack for one cycle only.
      req = WB_CYC_IN & WB_STB_IN & ~s_q.ack;
      s_d.ack = req;
      s_d.dat = '0;
      if (req && !WB_WE_IN) begin
         case (WB_ADR_IN)
            `AST_OFS_MODE: s_d.dat[7:0] = s_q.mode;
            `AST_OFS_STAT: s_d.dat[7:0] = {s_q.perr, s_q.ferr, s_q.overrun,
                                        s_q.rx_brk, s_q.brk_cmd,
                                        s_q.underrun, s_q.tx_free,
                                        s_q.rx_avail};
            `AST_OFS_HOLD: begin
               s_d.dat[7:0] = s_q.rhr;
               s_d.rx_avail = 1'b0; // see (RULE24)
            end
            `AST_OFS_CMD: s_d.dat[2:0] = {s_q.brk_cmd, s_q.rx_en, s_q.tx_en};
            `AST_OFS_BRR: s_d.dat[15:0] = s_q.bit_rate_control_reg;
            default: s_d.dat = '0;
         endcase
      end
      if (req && WB_WE_IN) begin
         case (WB_ADR_IN)
            `AST_OFS_MODE: begin
               // Format bits take effect on the character in flight.
               if (WB_SEL_IN[0]) begin
                  s_d.mode = WB_DAT_IN[7:0]; // see (RULE15)
               end
            end
            `AST_OFS_HOLD: begin
               // The CPU path to the transmitter is cut in echo mode.
               if (WB_SEL_IN[0] && !echo) begin // see (RULE20)
                  s_d.thr = WB_DAT_IN[7:0];
                  thr_new = 1'b1;
                  s_d.thr_full = 1'b1;
                  s_d.thr_echo = 1'b0;
                  s_d.underrun = 1'b0; // see (RULE9)
               end
            end
            `AST_OFS_CMD: begin
               if (WB_SEL_IN[0]) begin
                  s_d.tx_en = WB_DAT_IN[`AST_CMD_TX_EN];
                  s_d.rx_en = WB_DAT_IN[`AST_CMD_RX_EN];
                  s_d.brk_cmd = WB_DAT_IN[`AST_CMD_BREAK];
                  if (WB_DAT_IN[`AST_CMD_ERR_RST]) begin // see (RULE23)
                     s_d.overrun = 1'b0;
                     s_d.ferr = 1'b0;
                     s_d.perr = 1'b0;
                  end
               end
            end
            `AST_OFS_BRR: begin
               if (WB_SEL_IN[0]) begin
                  s_d.bit_rate_control_reg[7:0] = WB_DAT_IN[7:0];
               end
               if (WB_SEL_IN[1]) begin
                  s_d.bit_rate_control_reg[15:8] = WB_DAT_IN[15:8];
               end
            end
            default: s_d.mode = s_q.mode;
         endcase
      end

      // Receiver. Flag sets come after the bus so a set beats a clear.
      if (tick && s_q.rst != R_IDLE) begin
         s_d.rcnt = s_q.rcnt + 4'h1;
      end
      rsample = tick && (s_q.rcnt == `AST_FULL_BIT);
      case (s_q.rst)
         R_IDLE: begin
            if (s_q.rx_en && s_q.rx_p && !s_q.rx_s) begin
               s_d.rst = R_START;
               s_d.rcnt = 4'h0;
            end
         end
         R_START: begin
            if (tick && s_q.rcnt == `AST_HALF_BIT) begin // see (RULE27)
               s_d.rcnt = 4'h0;
               s_d.rbit = 3'd0;
               s_d.rsr = 8'h00;
               s_d.rst = s_q.rx_s ? R_IDLE : R_DATA; // see (RULE1) (RULE2)
            end
         end
         R_DATA: begin
            if (rsample) begin
               s_d.rsr[s_q.rbit] = s_q.rx_s; // see (RULE3)
               s_d.rbit = s_q.rbit + 3'd1;
               if (s_q.rbit >= last_bit) begin // see (RULE12)
                  s_d.rst = par_en ? R_PAR : R_STOP;
               end
            end
         end
         R_PAR: begin
            if (rsample) begin
               s_d.rpar = s_q.rx_s;
               s_d.rst = R_STOP;
            end
         end
         R_STOP: begin
            // Only one stop bit is ever checked.
            if (rsample) begin // see (RULE13)
               rx_load = 1'b1;
               s_d.rcnt = 4'h0;
               s_d.rhr = s_q.rsr & (8'hff >> (2'd3 - s_q.mode[1:0])); // see (RULE4)
               s_d.overrun = s_d.overrun | s_q.rx_avail; // see (RULE23)
               if (!s_q.rx_s && s_q.rsr == 8'h00 &&
                   !(par_en && s_q.rpar)) begin
                  rx_brk_ev = 1'b1;
                  s_d.rx_brk = 1'b1; // see (RULE7)
                  s_d.rst = R_BRKWAIT;
               end else begin
                  s_d.rx_avail = 1'b1; // see (RULE4)
                  s_d.ferr = s_d.ferr | ~s_q.rx_s; // see (RULE6)
                  s_d.perr = s_d.perr | (par_en && (s_q.rpar !=
                     ast_par_of(s_q.rsr, s_q.mode[1:0], s_q.mode[4:3],
                                s_q.mode[`AST_MODE_ODDEVEN]))); // see (RULE14)
                  // A low tail after a framing error may be a start bit.
                  s_d.rst = s_q.rx_s ? R_IDLE : R_START; // see (RULE5)
               end
               if (echo) begin // see (RULE18) (RULE22)
                  s_d.thr = s_d.rhr;
                  s_d.thr_par = s_q.rpar; // see (RULE21)
                  s_d.thr_echo = 1'b1;
                  thr_new = 1'b1;
                  s_d.thr_full = 1'b1;
               end
            end
         end
         R_BRKWAIT: begin
            if (!s_q.rx_s) begin
               s_d.rcnt = 4'h0;
            end else if (rsample) begin // see (RULE8)
               s_d.rx_brk = 1'b0;
               s_d.rst = R_IDLE;
            end
         end
         default: s_d.rst = R_IDLE;
      endcase

      // Transmitter. In echo mode it runs from the same receive tick and
      // needs no enable, which is why the two directions share one divider.
      if (tick && s_q.tst != T_IDLE) begin
         s_d.tcnt = s_q.tcnt + 4'h1;
      end
      tend = tick && (s_q.tcnt == `AST_FULL_BIT);
      case (s_q.tst)
         T_IDLE: s_d.tst = T_IDLE;
         T_START: begin
            if (tend) begin
               s_d.tst = T_DATA;
               s_d.tbit = 3'd0;
            end
         end
         T_DATA: begin
            if (tend) begin
               s_d.tbit = s_q.tbit + 3'd1;
               if (s_q.tbit >= last_bit) begin
                  s_d.tst = par_en ? T_PAR : T_STOP;
                  s_d.tstop2 = 1'b0;
               end
            end
         end
         T_PAR: begin
            if (tend) begin
               s_d.tst = T_STOP;
               s_d.tstop2 = 1'b0;
            end
         end
         T_STOP: begin
            if (tend) begin
               if (s_q.mode[`AST_MODE_STOP2] && !s_q.tstop2) begin // see (RULE13)
                  s_d.tstop2 = 1'b1;
               end else begin
                  stop_done = 1'b1;
                  s_d.tst = T_IDLE;
               end
            end
         end
         default: s_d.tst = T_IDLE;
      endcase
      // A character only starts while enabled or in echo mode; one in flight finishes.
      if ((s_q.tst == T_IDLE || stop_done) && s_q.thr_full &&
          (s_q.tx_en || echo) && !s_q.brk_cmd) begin // see (RULE11) (RULE19)
         s_d.tst = T_START;
         s_d.tcnt = 4'h0;
         s_d.tsr = s_q.thr;
         s_d.tpar = s_q.thr_par;
         s_d.tsr_echo = s_q.thr_echo;
         // Only a character written in this very cycle keeps the register full.
         s_d.thr_full = thr_new;
         s_d.underrun = 1'b0;
      end else if (stop_done && !s_q.thr_full && (s_q.tx_en || echo)) begin
         s_d.underrun = 1'b1; // see (RULE9)
      end
      if (!s_q.tx_en && !echo) begin
         s_d.underrun = 1'b0;
      end
      // Uses the new mode so that ready never shows in the first echo cycle.
      s_d.tx_free = ~s_d.thr_full & s_d.tx_en &
                    (s_d.mode[`AST_MODE_OP_LO +: 2] != 2'b01); // see (RULE20)

      case (s_d.tst)
         T_START: s_d.txd = 1'b0;
         T_DATA: s_d.txd = s_d.tsr[s_d.tbit]; // see (RULE3)
         T_PAR: s_d.txd = s_d.tsr_echo ? s_d.tpar :
            ast_par_of(s_d.tsr, s_d.mode[1:0], s_d.mode[4:3],
                       s_d.mode[`AST_MODE_ODDEVEN]); // see (RULE14) (RULE21)
         default: s_d.txd = 1'b1;
      endcase
      if (s_d.brk_cmd) begin
         s_d.txd = 1'b0; // see (RULE10)
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         s_q <= '0;
         s_q.rx_m <= 1'b1;
         s_q.rx_s <= 1'b1;
         s_q.rx_p <= 1'b1;
         s_q.txd <= 1'b1;
         s_q.mode <= `AST_RST_MODE;
         s_q.bit_rate_control_reg <= `AST_RST_BRR;
         s_q.rst <= R_IDLE;
         s_q.tst <= T_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign WB_ACK_OUT = s_q.ack;
   assign WB_DAT_OUT = s_q.dat;
   assign TXD_OUT = s_q.txd;

   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (RESET_IN);

   a_start_reject: assert property ( // see (RULE1)
      s_q.rst == R_START && tick && s_q.rcnt == 4'h7 && s_q.rx_s
      |=> s_q.rst == R_IDLE)
      else $error("False start bit was not rejected.");
   a_start_accept: assert property ( // see (RULE2)
      s_q.rst == R_START && tick && s_q.rcnt == 4'h7 && !s_q.rx_s
      |=> s_q.rst == R_DATA && s_q.rbit == 3'd0)
      else $error("Valid start bit was not accepted.");
   a_ready_set: assert property ( // see (RULE4)
      rx_load && !rx_brk_ev |=> s_q.rx_avail)
      else $error("Receive ready did not set.");
   a_upper_zero: assert property ( // see (RULE12)
      rx_load && s_q.mode[1:0] == 2'b00 |=> s_q.rhr[7:5] == 3'b000)
      else $error("Unused upper bits not zero.");
   a_break_rx: assert property ( // see (RULE7)
      rx_brk_ev && !s_q.rx_avail
      |=> s_q.rx_brk && s_q.rhr == 8'h00 && !s_q.rx_avail)
      else $error("Break character handled wrongly.");
   a_break_wait: assert property ( // see (RULE8)
      s_q.rst == R_BRKWAIT && !s_q.rx_s |=> s_q.rst == R_BRKWAIT)
      else $error("Left break wait while line low.");
   a_underrun_set: assert property ( // see (RULE9)
      stop_done && !s_q.thr_full && s_q.tx_en && !s_q.brk_cmd
      |=> s_q.underrun && TXD_OUT ##1 TXD_OUT)
      else $error("Underrun not flagged with line high.");
   a_break_low: assert property ( // see (RULE10)
      s_q.brk_cmd |-> !TXD_OUT)
      else $error("Transmit break did not hold the line low.");
   a_echo_free: assert property ( // see (RULE20)
      echo |-> !s_q.tx_free)
      else $error("Transmit ready set in echo mode.");
   a_overrun_set: assert property ( // see (RULE23)
      rx_load && s_q.rx_avail && !rx_brk_ev |=> s_q.overrun && s_q.rx_avail)
      else $error("Overrun not flagged.");
   a_read_clear: assert property ( // see (RULE24)
      req && !WB_WE_IN && WB_ADR_IN == `AST_OFS_HOLD && !rx_load
      |=> !s_q.rx_avail && WB_ACK_OUT ##1 !WB_ACK_OUT)
      else $error("Reading the holding register kept ready set.");
   a_echo_load: assert property ( // see (RULE18)
      rx_load && echo |=> s_q.thr_full || s_q.tst == T_START)
      else $error("Echo character not queued.");
   a_stop_once: assert property ( // see (RULE13)
      s_q.rst == R_STOP && rsample |=> s_q.rst != R_STOP)
      else $error("Receiver checked more than one stop bit.");
   a_break_clear: assert property ( // see (RULE8)
      s_q.rst == R_BRKWAIT && s_q.rx_s && rsample |=> !s_q.rx_brk)
      else $error("Break flag outlived a high bit time.");
   a_echo_break: assert property ( // see (RULE22)
      rx_brk_ev && echo |=> s_q.thr == 8'h00 && s_q.thr_full)
      else $error("Break character was not echoed.");
   a_flags_hold: assert property ( // see (RULE6)
      !rx_load && !(req && WB_WE_IN)
      |=> $stable(s_q.ferr) && $stable(s_q.perr))
      else $error("Error flag changed during assembly.");

   c_break: cover property (rx_brk_ev);
   c_echo: cover property (rx_load && echo);
   c_framing: cover property (rx_load && !s_q.rx_s && !rx_brk_ev);
   c_underrun: cover property (stop_done && !s_q.thr_full);

endmodule

/* File: pkg/ast_pkg.sv */
// Types and helper function shared by the serial transceiver.
package ast_pkg;

   typedef logic [31:0] ast_word_t;
   typedef logic [7:0] ast_byte_t;

   typedef enum logic [2:0] {
      R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRKWAIT
   } ast_rx_state_t;

   typedef enum logic [2:0] {
      T_IDLE, T_START, T_DATA, T_PAR, T_STOP
   } ast_tx_state_t;

   typedef struct packed {
      logic rx_m;
      logic rx_s;
      logic rx_p;
      logic [15:0] div;
      ast_rx_state_t rst;
      logic [3:0] rcnt;
      logic [2:0] rbit;
      ast_byte_t rsr;
      logic rpar;
      ast_tx_state_t tst;
      logic [3:0] tcnt;
      logic [2:0] tbit;
      ast_byte_t tsr;
      logic tpar;
      logic tsr_echo;
      logic tstop2;
      ast_byte_t mode;
      logic [15:0] bit_rate_control_reg;
      logic tx_en;
      logic rx_en;
      logic brk_cmd;
      ast_byte_t rhr;
      ast_byte_t thr;
      logic thr_full;
      logic thr_par;
      logic thr_echo;
      logic rx_avail;
      logic tx_free;
      logic underrun;
      logic rx_brk;
      logic overrun;
      logic ferr;
      logic perr;
      logic txd;
      logic ack;
      ast_word_t dat;
   } ast_state_t;

   // Parity bit for a character of the given length and format.
   function automatic logic ast_par_of(input ast_byte_t d,
                                       input logic [1:0] len,
                                       input logic [1:0] fmt,
                                       input logic even);
      logic ones;
      ones = ^(d & (8'hff >> (2'd3 - len)));
      if (fmt == 2'b01) begin
         return even;
      end
      return even ? ones : ~ones;
   endfunction

endpackage

/* File: pkg/ast_regs.svh */
// Register offsets, field positions, reset values and bit timing counts.
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

`define AST_OFS_MODE 8'h00
`define AST_OFS_STAT 8'h04
`define AST_OFS_HOLD 8'h08
`define AST_OFS_CMD 8'h0c
`define AST_OFS_BRR 8'h10

`define AST_MODE_LEN_LO 0
`define AST_MODE_STOP2 2
`define AST_MODE_PAR_LO 3
`define AST_MODE_ODDEVEN 5
`define AST_MODE_OP_LO 6

`define AST_CMD_TX_EN 0
`define AST_CMD_RX_EN 1
`define AST_CMD_BREAK 2
`define AST_CMD_ERR_RST 3

`define AST_RST_MODE 8'h00
`define AST_RST_BRR 16'h0103

`define AST_HALF_BIT 4'h7
`define AST_FULL_BIT 4'hf

`endif

/* File: verification/ast_remote_station.sv */
// Remote serial station: drives the receive line, decodes the send line.
`timescale 1ns/1ps
module ast_remote_station #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_in,
   input wire logic txd_in,
   input wire logic [3:0] nbits_in,
   input wire logic par_en_in,
   output logic rxd_out,
   output logic got_out,
   output logic [7:0] data_out,
   output logic par_out
);
   initial begin
      rxd_out = 1'b1;
      got_out = 1'b0;
      data_out = 8'h00;
      par_out = 1'b0;
   end

   task automatic bit_out(input logic b);
      rxd_out <= b;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask

   // A low stop is cut short so that the line is high again before the
   // receiver could mistake the tail for a new start bit.
   task automatic send(input logic [7:0] d, input int n, input logic pe,
                       input logic p, input logic stop);
      bit_out(1'b0);
      for (int k = 0; k < n; k++) bit_out(d[k]);
      if (pe) bit_out(p);
      rxd_out <= stop;
      repeat (stop ? BIT_CLKS : BIT_CLKS * 3 / 4) @(posedge clk_in);
      rxd_out <= 1'b1;
      @(posedge clk_in);
   endtask

   task automatic hold_low(input int nbits);
      rxd_out <= 1'b0;
      repeat (nbits * BIT_CLKS) @(posedge clk_in);
      rxd_out <= 1'b1;
      @(posedge clk_in);
   endtask

   // Bits are judged at their centres; a frame with a low stop is dropped.
   always begin : decode
      logic [7:0] d;
      logic p;
      @(negedge txd_in);
      d = 8'h00;
      p = 1'b0;
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      if (txd_in === 1'b0) begin
         for (int k = 0; k < nbits_in; k++) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            d[k] = txd_in;
         end
         if (par_en_in) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            p = txd_in;
         end
         repeat (BIT_CLKS) @(posedge clk_in);
         if (txd_in === 1'b1) begin
            data_out <= d;
            par_out <= p;
            got_out <= 1'b1;
            @(posedge clk_in);
            got_out <= 1'b0;
         end
      end
   end
endmodule

/* File: verification/test_ast_uart.sv */
// Self-checking bench for the serial transceiver and a remote station.
`timescale 1ns/1ps
`include "ast_regs.svh"
module test_ast_uart;
   import ast_pkg::*;
   logic clk;
   logic rst;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   ast_word_t dat_w;
   ast_word_t dat_r;
   logic ack;
   logic rxd;
   logic txd;
   logic got;
   logic [7:0] s_dat;
   logic s_par;
   logic [3:0] nbits;
   logic pe;
   int bad_count;
   int num_checks;
   int seed;
   ast_word_t rd_exp[$];
   ast_word_t rd_msk[$];
   ast_word_t ser_exp[$];
   ast_word_t e;

   ast_uart i_ast_uart (
      .CLK_SYS_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w),
      .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .RXD_IN(rxd), .TXD_OUT(txd));

   ast_remote_station i_ast_remote_station (
      .clk_in(clk), .txd_in(txd), .nbits_in(nbits), .par_en_in(pe),
      .rxd_out(rxd), .got_out(got), .data_out(s_dat), .par_out(s_par));

   task automatic report_and_stop();
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input ast_word_t seen, input ast_word_t want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input ast_word_t d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         report_and_stop();
      end
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input ast_word_t x, input ast_word_t m);
      rd_exp.push_back(x & m);
      rd_msk.push_back(m);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic wait_ser();
      int n;
      n = 0;
      while (ser_exp.size() != 0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      if (n >= 600) begin
         bad_count++;
         report_and_stop();
      end
   endtask

   // A set odd/even bit asks for even parity.
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] f,
                                    input logic ev);
      if (f == 2'b01) return ev;
      return ev ? ^d : ~^d;
   endfunction

   // Results are compared in the cycle that they appear on the ports.
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         e = rd_msk.pop_front();
         check(dat_r & e, rd_exp.pop_front());
      end
      if (got === 1'b1) begin
         e = (ser_exp.size() != 0) ? ser_exp.pop_front() : 32'hffffffff;
         check({23'h0, s_par, s_dat}, e);
      end
   end

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] t;
      logic [7:0] mk;
      logic [1:0] fmt;
      logic ev;
      logic perr;
      seed = 97;
      bad_count = 0;
      num_checks = 0;
      {cyc, stb, we, adr, sel, dat_w} = '0;
      nbits = 4'h8;
      pe = 1'b0;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`AST_OFS_MODE, 32'h0, 32'hff);
      rd(`AST_OFS_BRR, 32'h103, 32'hffff);
      rd(8'h14, 32'h0, 32'hffffffff);
      rd(`AST_OFS_STAT, 32'h0, 32'hff);
      wb(1'b1, `AST_OFS_BRR, 32'h0);
      // The divider takes the new rate only at its next terminal count.
      repeat (270) @(posedge clk);
      wb(1'b1, `AST_OFS_CMD, 32'h3);
      for (int i = 0; i < 12; i++) begin
         fmt = 2'(i / 4);
         ev = 1'($random(seed));
         mk = 8'hff >> (3 - i % 4);
         perr = (i == 5);
         nbits <= 4'(5 + i % 4);
         pe <= (fmt != 2'b00);
         wb(1'b1, `AST_OFS_MODE, {24'h0, 2'b00, ev, fmt, 1'($random(seed)),
            2'(i)});
         d = 8'($random(seed)) & mk;
         t = 8'($random(seed));
         ser_exp.push_back({23'h0, (fmt != 2'b00) & par_bit(t & mk, fmt, ev),
            t & mk});
         wb(1'b1, `AST_OFS_HOLD, {24'h0, t});
         i_ast_remote_station.send(d, 5 + i % 4, fmt != 2'b00,
            par_bit(d, fmt, ev) ^ perr, 1'b1);
         wait_ser();
         repeat (40) @(posedge clk);
         rd(`AST_OFS_STAT, {24'h0, perr, 7'h07}, 32'hff);
         rd(`AST_OFS_HOLD, {24'h0, d}, 32'hffffffff);
         rd(`AST_OFS_STAT, {24'h0, perr, 7'h06}, 32'hff);
         if (perr) wb(1'b1, `AST_OFS_CMD, 32'hb);
      end
      nbits <= 4'h8;
      pe <= 1'b0;
      wb(1'b1, `AST_OFS_MODE, 32'h3);
      i_ast_remote_station.send(8'h5a, 8, 1'b0, 1'b0, 1'b1);
      i_ast_remote_station.send(8'ha5, 8, 1'b0, 1'b0, 1'b0);
      rd(`AST_OFS_STAT, 32'h67, 32'hff);
      rd(`AST_OFS_HOLD, 32'ha5, 32'hff);
      wb(1'b1, `AST_OFS_CMD, 32'hb);
      rd(`AST_OFS_STAT, 32'h06, 32'hff);
      i_ast_remote_station.hold_low(11);
      rd(`AST_OFS_STAT, 32'h16, 32'hff);
      repeat (24) @(posedge clk);
      rd(`AST_OFS_STAT, 32'h06, 32'hff);
      rd(`AST_OFS_HOLD, 32'h0, 32'hff);
      wb(1'b1, `AST_OFS_CMD, 32'h7);
      rd(`AST_OFS_STAT, 32'h08, 32'h08);
      for (int k = 0; k < 8; k++) begin
         repeat (25) @(posedge clk);
         check({31'h0, txd}, 32'h0);
      end
      wb(1'b1, `AST_OFS_CMD, 32'h3);
      ser_exp.push_back(32'h3c);
      wb(1'b1, `AST_OFS_HOLD, 32'h3c);
      repeat (48) @(posedge clk);
      wb(1'b1, `AST_OFS_CMD, 32'h2);
      wait_ser();
      // The operating mode is only changed with both directions disabled.
      wb(1'b1, `AST_OFS_CMD, 32'h0);
      wb(1'b1, `AST_OFS_MODE, 32'h73);
      wb(1'b1, `AST_OFS_CMD, 32'h2);
      wb(1'b1, `AST_OFS_HOLD, 32'hff);
      pe <= 1'b1;
      ser_exp.push_back(32'h1c3);
      i_ast_remote_station.send(8'hc3, 8, 1'b1, 1'b1, 1'b1);
      wait_ser();
      rd(`AST_OFS_STAT, 32'h81, 32'h83);
      rd(`AST_OFS_HOLD, 32'hc3, 32'hff);
      ser_exp.push_back(32'h0);
      i_ast_remote_station.hold_low(11);
      wait_ser();
      repeat (40) @(posedge clk);
      if (ser_exp.size() != 0 || rd_exp.size() != 0) bad_count++;
      report_and_stop();
   end
endmodule
